//--- hw/nipc_ctrl.sv
`timescale 1ns/100ps

// How it works
// - Four levels, sixteen vectors, reset, trap and pin interrupt non-maskable.
// - Vector addresses FFE0h to FFFFh, descending with hardware priority.
// - Current priority held in flags bits 5 (high) and 3 (low).
// - Pairs 10, 01, 00, 11 mean levels 0, 1, 2, 3.
// - Entry starts only at an instruction boundary, except reset entry.
// - Program counter, index, accumulator and flags are pushed on entry; reset entry pushes nothing.
// - Then priority bits load, vector loads, first handler fetch issued.
// - Return restores the stacked flags including both priority bits.
// - Highest software level wins, ties go to higher fixed order.
// - Unserved requests stay latched until they become the winner.
// - Non-maskable sources ignore level, set level 3; of them only pin interrupt wakes from halt.
// - Pin interrupt raised by the chosen edge on its own pin.
// - Trap handled like pin interrupt; pin interrupt may preempt trap.
// - Reset is highest; reset routine runs at level 3.
// - Maskable taken only if enabled and above current level.
// - Edge external requests latch and clear on service entry.
// - Selected pins of one group are NANDed onto the line.
// - Peripheral request needs both its flag and its enable.
// - Clear sequence from software drops the peripheral latch.
// - Any source wakes wait; halt wake and first entry need capability.
// - After the first entry a non-capable winner competes normally, so it waits behind the first handler's level.
// - Concurrent mode blocks maskable preemption; nested mode allows higher levels.
// - Priority registers reset to all ones, level 3.
// - Writing pair 10 to a priority slot keeps the old pair.
module nipc_ctrl #(
  parameter int NUM_SRC = `NIPC_NUM_SRC,
  parameter int EXT_GRP = 3,
  parameter int EXT_PINS = 8,
  parameter logic [4*EXT_GRP-1:0] EXT_SRC = 12'h962,
  parameter logic [NUM_SRC-1:0] HALT_CAP = 14'h3E67,
  parameter logic TLI_RISING = 1'b0
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic [NUM_SRC-1:0]            i_periph_flag,
  input  wire logic [NUM_SRC-1:0]            i_periph_en,
  input  wire logic [NUM_SRC-1:0]            i_src_clear,
  input  wire logic [EXT_GRP*EXT_PINS-1:0]   i_ext_pins,
  input  wire logic [EXT_GRP*EXT_PINS-1:0]   i_ext_pin_sel,
  input  wire logic [2*EXT_GRP-1:0]          i_ext_sense_select,
  input  wire logic                          i_top_level_pin_irq,
  input  wire logic                          i_trap,
  input  wire logic                          i_instr_boundary,
  input  wire logic                          i_prio_wr_en,
  input  wire logic [1:0]                    i_prio_wr_idx,
  input  wire logic [7:0]                    i_prio_wr_data,
  input  wire logic                          i_cc_wr_en,
  input  wire logic [7:0]                    i_cc_wr_data,
  input  wire logic                          i_return_from_irq,
  input  wire logic [7:0]                    i_pop_cc,
  input  wire logic [15:0]                   i_pc,
  input  wire logic [7:0]                    i_x,
  input  wire logic [7:0]                    i_a,
  input  wire logic                          i_wait_mode,
  input  wire logic                          i_halt_mode,
  input  wire logic                          i_concurrent_mode,
  output nipc_pkg::nipc_arb_t                o_irq,
  output nipc_pkg::nipc_push_t               o_push,
  output logic                               o_pc_load,
  output logic [15:0]                        o_pc_vector,
  output logic                               o_fetch,
  output logic                               o_busy,
  output logic                               o_wake,
  output logic [7:0]                         o_cpu_flags_register,
  output logic [31:0]                        o_vector_priority_regs
);
  import nipc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // pair 10 is not writable
  function automatic logic [7:0] prio_merge(input logic [7:0] old_v, input logic [7:0] new_v);
    logic [7:0] r;
    r = new_v;
    for (int p = 0; p < 4; p++) begin
      if (new_v[2*p+:2] == `NIPC_PAIR_LVL0) begin
        r[2*p+:2] = old_v[2*p+:2];
      end
    end
    return r;
  endfunction

  // two bytes per vector below the top
  function automatic logic [15:0] vec_addr(input logic [3:0] idx);
    return `NIPC_VEC_TOP - {11'h000, idx, 1'b0};
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  nipc_state_t state_r;
  nipc_state_t state_nxt;
  nipc_arb_t arb;
  logic [31:0] prio_r;
  logic [7:0] cc_r;
  logic [NUM_SRC-1:0] pend_r;
  logic [NUM_SRC-1:0] ext_req;
  logic [NUM_SRC-1:0] entry_clr;
  logic [EXT_GRP-1:0] ext_line;
  logic [EXT_GRP-1:0] ext_prev_r;
  logic [EXT_GRP-1:0] ext_lat_r;
  logic tli_prev_r;
  logic tli_lat_r;
  logic trap_lat_r;
  logic rst_lat_r;
  logic halt_exit_r;
  logic [3:0] depth_r;
  logic [2:0] push_cnt_r;
  logic [3:0] sel_idx_r;
  logic [15:0] pc_cap_r;
  logic [7:0] x_cap_r;
  logic [7:0] a_cap_r;
  logic accept;
  logic [1:0] sel_pair;
  logic any_req;
  logic any_halt_req;
  logic [NUM_SRC-1:0] all_pend;

  // ----------------------------------------
  // Source conditioning
  // ----------------------------------------
  always_comb begin
    for (int g = 0; g < EXT_GRP; g++) begin
      ext_line[g] = ~&(i_ext_pins[g*EXT_PINS+:EXT_PINS] | ~i_ext_pin_sel[g*EXT_PINS+:EXT_PINS]);
    end
  end

  always_comb begin
    ext_req = '0;
    for (int g = 0; g < EXT_GRP; g++) begin
      if (i_ext_sense_select[2*g+:2] == `NIPC_SENSE_LEVEL) begin
        ext_req[EXT_SRC[4*g+:4]] = ext_req[EXT_SRC[4*g+:4]] | ext_line[g];
      end else begin
        ext_req[EXT_SRC[4*g+:4]] = ext_req[EXT_SRC[4*g+:4]] | ext_lat_r[g];
      end
    end
  end

  // Entry clears only edge latches, never peripheral flags
  always_comb begin
    entry_clr = '0;
    if (state_r == NIPC_ST_VECT && sel_idx_r > `NIPC_IDX_SRC_BASE) begin
      entry_clr[sel_idx_r - `NIPC_IDX_SRC_BASE] = 1'b1;
    end
  end

  // edge latch, set beats entry clear
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ext_prev_r <= '0;
      ext_lat_r <= '0;
    end else begin
      ext_prev_r <= ext_line;
      for (int g = 0; g < EXT_GRP; g++) begin
        logic rise;
        logic fall;
        logic hit;
        rise = ext_line[g] & ~ext_prev_r[g];
        fall = ~ext_line[g] & ext_prev_r[g];
        hit = 1'b0;
        unique case (i_ext_sense_select[2*g+:2])
          `NIPC_SENSE_LEVEL: hit = 1'b0;
          `NIPC_SENSE_RISE: hit = rise;
          `NIPC_SENSE_FALL: hit = fall;
          `NIPC_SENSE_BOTH: hit = rise | fall;
        endcase
        ext_lat_r[g] <= hit | (ext_lat_r[g] & ~entry_clr[EXT_SRC[4*g+:4]]);
      end
    end
  end

  // flag and enable; held through service
  // software clear sequence drops the latch
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (i_periph_flag & i_periph_en) | (pend_r & ~i_src_clear);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tli_prev_r <= 1'b0;
      tli_lat_r <= 1'b0;
    end else begin
      tli_prev_r <= i_top_level_pin_irq;
      tli_lat_r <= (TLI_RISING ? (i_top_level_pin_irq & ~tli_prev_r)
                               : (~i_top_level_pin_irq & tli_prev_r))
                   | (tli_lat_r & ~(state_r == NIPC_ST_VECT && sel_idx_r == `NIPC_IDX_TLI));
    end
  end

  // reset source pending from reset onward
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      trap_lat_r <= 1'b0;
      rst_lat_r <= 1'b1;
    end else begin
      trap_lat_r <= i_trap | (trap_lat_r & ~(state_r == NIPC_ST_VECT && sel_idx_r == `NIPC_IDX_TRAP));
      if (accept && arb.idx == `NIPC_IDX_RESET) begin
        rst_lat_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  // Slot 0 of the priority map is unused by the decision
  assign all_pend = {pend_r[NUM_SRC-1:1] | ext_req[NUM_SRC-1:1], tli_lat_r};

  // concurrent mode blocks maskable inside a handler
  nipc_arbiter #(
    .NUM_SRC(NUM_SRC)
  ) u_arb (
    .i_pend(all_pend),
    .i_rst_req(rst_lat_r),
    .i_trap_req(trap_lat_r),
    .i_prio(prio_r[2*NUM_SRC-1:0]),
    .i_cur_pair({cc_r[`NIPC_CC_HIGH_POS], cc_r[`NIPC_CC_LOW_POS]}),
    .i_halt_restrict(halt_exit_r),
    .i_halt_cap(HALT_CAP),
    .i_block_maskable(i_concurrent_mode && depth_r != 4'h0),
    .o_sel(arb)
  );

  // only at a boundary, reset needs none
  assign accept = (state_r == NIPC_ST_IDLE) && arb.valid
                  && (i_instr_boundary || arb.idx == `NIPC_IDX_RESET);

  assign sel_pair = (sel_idx_r > `NIPC_IDX_SRC_BASE)
                    ? prio_r[2*(sel_idx_r - `NIPC_IDX_SRC_BASE)+:2] : `NIPC_PAIR_LVL3;

  // ----------------------------------------
  // Entry sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      NIPC_ST_IDLE: begin
        if (accept) begin
          state_nxt = (arb.idx == `NIPC_IDX_RESET) ? NIPC_ST_VECT : NIPC_ST_PUSH;
        end
      end
      NIPC_ST_PUSH: begin
        if (push_cnt_r == `NIPC_STACK_LAST) begin
          state_nxt = NIPC_ST_VECT;
        end
      end
      NIPC_ST_VECT: state_nxt = NIPC_ST_FETCH;
      NIPC_ST_FETCH: state_nxt = NIPC_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_r <= NIPC_ST_IDLE;
      push_cnt_r <= 3'h0;
      sel_idx_r <= 4'h0;
      pc_cap_r <= 16'h0000;
      x_cap_r <= 8'h00;
      a_cap_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      push_cnt_r <= (state_r == NIPC_ST_PUSH) ? push_cnt_r + 3'h1 : 3'h0;
      if (accept) begin
        sel_idx_r <= arb.idx;
        pc_cap_r <= i_pc;
        x_cap_r <= i_x;
        a_cap_r <= i_a;
      end
    end
  end

  // push PC, X, A, CC in turn
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_push <= '0;
    end else begin
      o_push.valid <= (state_r == NIPC_ST_PUSH);
      o_push.item <= nipc_item_t'(push_cnt_r);
      unique case (push_cnt_r)
        3'h0: o_push.data <= pc_cap_r[7:0];
        3'h1: o_push.data <= pc_cap_r[15:8];
        3'h2: o_push.data <= x_cap_r;
        3'h3: o_push.data <= a_cap_r;
        default: o_push.data <= cc_r;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pc_load <= 1'b0;
      o_pc_vector <= `NIPC_VEC_TOP;
      o_fetch <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_pc_load <= (state_r == NIPC_ST_VECT);
      if (state_r == NIPC_ST_VECT) begin
        o_pc_vector <= vec_addr(sel_idx_r);
      end
      o_fetch <= (state_r == NIPC_ST_FETCH);
      o_busy <= (state_nxt != NIPC_ST_IDLE);
    end
  end

  // index and valid for the core
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_irq <= '0;
    end else begin
      o_irq.valid <= arb.valid && (state_nxt == NIPC_ST_IDLE) && !accept;
      o_irq.idx <= arb.idx;
    end
  end

  // ----------------------------------------
  // Flags and priority registers
  // ----------------------------------------
  // priority bits live at 5 and 3
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cc_r <= `NIPC_CC_RESET;
    end else if (state_r == NIPC_ST_VECT) begin
      // load pair of the serviced vector; NMI gives level 3
      cc_r[`NIPC_CC_HIGH_POS] <= sel_pair[1];
      cc_r[`NIPC_CC_LOW_POS] <= sel_pair[0];
    end else if (i_return_from_irq) begin
      cc_r <= i_pop_cc;
    end else if (i_cc_wr_en) begin
      cc_r <= i_cc_wr_data;
    end
  end

  // all ones at reset; top nibble stays read-only ones
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      prio_r <= `NIPC_PRIO_RESET;
    end else if (i_prio_wr_en) begin
      if (i_prio_wr_idx == 2'h3) begin
        prio_r[27:24] <= 4'(prio_merge({4'hF, prio_r[27:24]}, i_prio_wr_data));
      end else begin
        prio_r[8*i_prio_wr_idx+:8] <= prio_merge(prio_r[8*i_prio_wr_idx+:8], i_prio_wr_data);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_cpu_flags_register <= `NIPC_CC_RESET;
      o_vector_priority_regs <= `NIPC_PRIO_RESET;
    end else begin
      o_cpu_flags_register <= cc_r;
      o_vector_priority_regs <= prio_r;
    end
  end

  // Nesting depth; overflow of the stack is not detected
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      depth_r <= 4'h0;
    end else if (state_r == NIPC_ST_VECT && sel_idx_r != `NIPC_IDX_RESET) begin
      depth_r <= (depth_r == 4'hF) ? depth_r : depth_r + 4'h1;
    end else if (i_return_from_irq && depth_r != 4'h0) begin
      depth_r <= depth_r - 4'h1;
    end
  end

  // ----------------------------------------
  // Low-power wake
  // ----------------------------------------
  assign any_req = tli_lat_r | trap_lat_r | (|(pend_r | ext_req));
  assign any_halt_req = |(all_pend & HALT_CAP);

  // wait wakes on anything, halt on capable only
  // restriction holds for the first entry only
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_wake <= 1'b0;
      halt_exit_r <= 1'b0;
    end else begin
      o_wake <= (i_wait_mode && any_req) || (i_halt_mode && any_halt_req);
      if (i_halt_mode && any_halt_req) begin
        halt_exit_r <= 1'b1;
      end else if (accept) begin
        halt_exit_r <= 1'b0;
      end
    end
  end

endmodule

//--- include/nipc_params.svh
`ifndef NIPC_PARAMS_SVH
`define NIPC_PARAMS_SVH

// ----------------------------------------
// Source and vector counts
// ----------------------------------------
`define NIPC_NUM_SRC 14
`define NIPC_NUM_VEC 16
`define NIPC_NUM_LVL 4
`define NIPC_NUM_NMI 3

// ----------------------------------------
// Vector map
// ----------------------------------------
`define NIPC_VEC_TOP 16'hFFFE
`define NIPC_VEC_BOTTOM 16'hFFE0
`define NIPC_IDX_RESET 4'h0
`define NIPC_IDX_TRAP 4'h1
`define NIPC_IDX_TLI 4'h2
`define NIPC_IDX_SRC_BASE 4'h2

// ----------------------------------------
// CPU flags register
// ----------------------------------------
`define NIPC_CC_RESET 8'hFA
`define NIPC_CC_HIGH_POS 5
`define NIPC_CC_LOW_POS 3

// ----------------------------------------
// Priority pairs (high,low)
// ----------------------------------------
`define NIPC_PRIO_RESET 32'hFFFFFFFF
`define NIPC_PAIR_LVL0 2'b10
`define NIPC_PAIR_LVL1 2'b01
`define NIPC_PAIR_LVL2 2'b00
`define NIPC_PAIR_LVL3 2'b11

// ----------------------------------------
// External sense codes
// ----------------------------------------
`define NIPC_SENSE_LEVEL 2'b00
`define NIPC_SENSE_RISE 2'b01
`define NIPC_SENSE_FALL 2'b10
`define NIPC_SENSE_BOTH 2'b11

// ----------------------------------------
// Stacking
// ----------------------------------------
`define NIPC_STACK_LAST 3'h4

`endif

//--- include/nipc_pkg.sv
`include "nipc_params.svh"

package nipc_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    NIPC_ST_IDLE  = 4'h1,
    NIPC_ST_PUSH  = 4'h2,
    NIPC_ST_VECT  = 4'h4,
    NIPC_ST_FETCH = 4'h8
  } nipc_state_t;

  typedef enum logic [2:0] {
    NIPC_ITEM_PCL = 3'h0,
    NIPC_ITEM_PCH = 3'h1,
    NIPC_ITEM_X   = 3'h2,
    NIPC_ITEM_A   = 3'h3,
    NIPC_ITEM_CC  = 3'h4
  } nipc_item_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] idx;
  } nipc_arb_t;

  typedef struct packed {
    logic       valid;
    nipc_item_t item;
    logic [7:0] data;
  } nipc_push_t;

  // Level 0..3 from a (high,low) pair
  function automatic logic [1:0] nipc_lvl(input logic [1:0] pair);
    logic [1:0] l;
    l = 2'h0;
    unique case (pair)
      `NIPC_PAIR_LVL0: l = 2'h0;
      `NIPC_PAIR_LVL1: l = 2'h1;
      `NIPC_PAIR_LVL2: l = 2'h2;
      `NIPC_PAIR_LVL3: l = 2'h3;
    endcase
    return l;
  endfunction

endpackage

//--- hw/nipc_arbiter.sv
`timescale 1ns/100ps

module nipc_arbiter #(
  parameter int NUM_SRC = `NIPC_NUM_SRC
) (
  input  wire logic [NUM_SRC-1:0]   i_pend,
  input  wire logic                 i_rst_req,
  input  wire logic                 i_trap_req,
  input  wire logic [2*NUM_SRC-1:0] i_prio,
  input  wire logic [1:0]           i_cur_pair,
  input  wire logic                 i_halt_restrict,
  input  wire logic [NUM_SRC-1:0]   i_halt_cap,
  input  wire logic                 i_block_maskable,
  output nipc_pkg::nipc_arb_t       o_sel
);
  import nipc_pkg::*;

  // ----------------------------------------
  // Two-step decision
  // ----------------------------------------
  always_comb begin
    logic [1:0] best;
    logic [1:0] lv;
    logic       ok;
    best = 2'h0;
    lv = 2'h0;
    ok = 1'b0;
    o_sel = '0;
    // level first, then fixed order
    // Walk lowest order upward so lower index wins ties
    for (int s = NUM_SRC - 1; s >= 1; s--) begin
      lv = nipc_lvl(i_prio[2*s+:2]);
      ok = i_pend[s] && (lv > nipc_lvl(i_cur_pair)) && !i_block_maskable;
      // halt exit takes a capable one first
      ok = ok && (!i_halt_restrict || i_halt_cap[s]);
      if (ok && (!o_sel.valid || lv >= best)) begin
        best = lv;
        o_sel.valid = 1'b1;
        o_sel.idx = 4'(s) + `NIPC_IDX_SRC_BASE;
      end
    end
    if (i_pend[0] && (!i_halt_restrict || i_halt_cap[0])) begin
      o_sel.valid = 1'b1;
      o_sel.idx = `NIPC_IDX_TLI;
    end
    if (i_trap_req) begin
      o_sel.valid = 1'b1;
      o_sel.idx = `NIPC_IDX_TRAP;
    end
    if (i_rst_req) begin
      o_sel.valid = 1'b1;
      o_sel.idx = `NIPC_IDX_RESET;
    end
  end

endmodule

//--- sim/nipc_ctrl_asserts.sv
`timescale 1ns/100ps

module nipc_ctrl_asserts #(
  parameter int NUM_SRC = 14
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [NUM_SRC-1:0] i_periph_flag,
  input wire logic [NUM_SRC-1:0] i_periph_en,
  input wire logic i_instr_boundary,
  input wire logic i_prio_wr_en,
  input wire logic [7:0] i_prio_wr_data,
  input wire logic i_cc_wr_en,
  input wire logic i_return_from_irq,
  input wire logic [7:0] i_pop_cc,
  input wire logic i_wait_mode,
  input wire nipc_pkg::nipc_push_t o_push,
  input wire logic o_pc_load,
  input wire logic [15:0] o_pc_vector,
  input wire logic o_fetch,
  input wire logic o_busy,
  input wire logic o_wake,
  input wire logic [7:0] o_cpu_flags_register,
  input wire logic [31:0] o_vector_priority_regs
);
  import nipc_pkg::*;
  // ------
  // Entry sequence
  // ------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  property p_push_order;
    o_push.valid && o_push.item == NIPC_ITEM_PCL |=> o_push.item == NIPC_ITEM_PCH
      ##1 o_push.item == NIPC_ITEM_X ##1 o_push.item == NIPC_ITEM_A
      ##1 o_push.valid && o_push.item == NIPC_ITEM_CC;
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order broken");
  property p_cc_load;
    o_push.valid && o_push.item == NIPC_ITEM_CC |=> o_pc_load ##1 o_fetch && !o_busy;
  endproperty
  a_cc_load: assert property (p_cc_load) else $error("load or fetch missing");
  property p_vec;
    o_pc_load |-> o_pc_vector >= 16'hFFE0 && !o_pc_vector[0] && $past(o_busy);
  endproperty
  a_vec: assert property (p_vec) else $error("vector out of map");
  property p_nmi;
    o_pc_load && o_pc_vector >= 16'hFFFA |-> ##[0:2] o_cpu_flags_register[5] && o_cpu_flags_register[3];
  endproperty
  a_nmi: assert property (p_nmi) else $error("level not raised to 3");
  // Reset entry needs no boundary
  property p_bnd;
    $rose(o_busy) && !$past(i_sys_rst, 2) && !$past(i_sys_rst, 3) |-> $past(i_instr_boundary);
  endproperty
  a_bnd: assert property (p_bnd) else $error("entry off boundary");
  property p_ret;
    i_return_from_irq && !o_busy ##1 !i_cc_wr_en && !i_return_from_irq
      |=> o_cpu_flags_register == $past(i_pop_cc, 2);
  endproperty
  a_ret: assert property (p_ret) else $error("flags not restored");
  property p_lvl0;
    i_prio_wr_en && i_prio_wr_data == 8'hAA ##1 !i_prio_wr_en
      |=> o_vector_priority_regs == $past(o_vector_priority_regs);
  endproperty
  a_lvl0: assert property (p_lvl0) else $error("level 0 pair stored");
  property p_rst;
    $fell(i_sys_rst) |-> ##[1:6] o_pc_load && o_pc_vector == 16'hFFFE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset entry missing");
  property p_wake;
    i_wait_mode && |(i_periph_flag & i_periph_en) |-> ##[1:3] o_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from wait");
  c_trap: cover property (o_pc_load && o_pc_vector == 16'hFFFC);
  c_ret: cover property (i_return_from_irq);
  c_wake: cover property (o_wake);
endmodule

bind nipc_ctrl nipc_ctrl_asserts #(.NUM_SRC(NUM_SRC)) i_nipc_ctrl_asserts (.*);

//--- sim/nipc_core_model.sv
`timescale 1ns/100ps

module nipc_core_model #(
  parameter logic [15:0] PC = 16'h1234,
  parameter logic [7:0] X = 8'h5A,
  parameter logic [7:0] A = 8'hC3
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_sleep,
  input wire logic i_slow,
  output logic o_boundary,
  output logic [15:0] o_pc,
  output logic [7:0] o_x,
  output logic [7:0] o_a
);
  logic [1:0] cnt_r;
  assign o_pc = PC;
  assign o_x = X;
  assign o_a = A;
  // Instruction completion pulse
  // Asleep: none; slow: every fourth
  always_ff @(posedge i_ref_clk) begin
    cnt_r <= i_sys_rst ? 2'h0 : cnt_r + 2'h1;
    o_boundary <= !i_sys_rst && !i_sleep && (!i_slow || cnt_r == 2'h3);
  end
endmodule

//--- sim/test_nested_priority_interrupt_ctrl.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module test_nested_priority_interrupt_ctrl;
  import nipc_pkg::*;
  localparam logic [15:0] CPC = 16'h1234;
  localparam logic [7:0] CX = 8'h5A;
  localparam logic [7:0] CA = 8'hC3;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst, i_instr_boundary, i_top_level_pin_irq, i_trap, i_prio_wr_en, i_cc_wr_en;
  logic i_return_from_irq, i_wait_mode, i_halt_mode, i_concurrent_mode, sleep, slow;
  logic [13:0] i_periph_flag, i_periph_en, i_src_clear;
  logic [23:0] i_ext_pins, i_ext_pin_sel;
  logic [5:0] i_ext_sense_select;
  logic [1:0] i_prio_wr_idx;
  logic [7:0] i_prio_wr_data, i_cc_wr_data, i_pop_cc, i_x, i_a, o_cpu_flags_register;
  logic [15:0] i_pc, o_pc_vector;
  nipc_arb_t o_irq;
  nipc_push_t o_push;
  logic o_pc_load, o_fetch, o_busy, o_wake;
  logic [31:0] o_vector_priority_regs;

  always #12.5 i_ref_clk = ~i_ref_clk;
  assign sleep = i_halt_mode | i_wait_mode;

  nipc_ctrl i_nipc_ctrl (.*);
  nipc_core_model #(.PC(CPC), .X(CX), .A(CA)) i_nipc_core_model (.i_ref_clk, .i_sys_rst,
    .i_sleep(sleep), .i_slow(slow), .o_boundary(i_instr_boundary), .o_pc(i_pc), .o_x(i_x),
    .o_a(i_a));

  // ------
  // Shared tasks
  // ------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  task automatic look(input int n);
    tick(n);
    #1;
  endtask

  task automatic enter(input logic [15:0] vec, input logic [1:0] pr, input logic [7:0] cc,
                       input int np);
    logic [7:0] want [5];
    int k;
    int n;
    want = '{CPC[7:0], CPC[15:8], CX, CA, cc};
    k = 0;
    n = 0;
    while (o_busy !== 1'b1 && n < 60) begin
      look(1);
      n++;
    end
    `CHK("entry", 1'b1, o_busy)
    while (o_fetch !== 1'b1 && n < 90) begin
      if (o_push.valid === 1'b1) begin
        `CHK("push", want[k], o_push.data)
        k++;
      end
      if (o_pc_load === 1'b1) `CHK("vector", vec, o_pc_vector)
      look(1);
      n++;
    end
    `CHK("pushes", np, k)
    look(2);
    `CHK("level", pr, {o_cpu_flags_register[5], o_cpu_flags_register[3]})
  endtask

  task automatic ret(input logic [7:0] cc);
    tick(1);
    i_return_from_irq <= 1'b1;
    i_pop_cc <= cc;
    tick(1);
    i_return_from_irq <= 1'b0;
    look(2);
    `CHK("flags", cc, o_cpu_flags_register)
  endtask

  task automatic wprio(input int idx, input logic [7:0] d, input logic [7:0] ex);
    tick(1);
    i_prio_wr_en <= 1'b1;
    i_prio_wr_idx <= idx[1:0];
    i_prio_wr_data <= d;
    tick(1);
    i_prio_wr_en <= 1'b0;
    look(2);
    `CHK("prio", ex, o_vector_priority_regs[8*idx+:8])
  endtask

  task automatic setcc(input logic [7:0] d);
    tick(1);
    i_cc_wr_en <= 1'b1;
    i_cc_wr_data <= d;
    tick(1);
    i_cc_wr_en <= 1'b0;
  endtask

  task automatic raise(input int s);
    tick(1);
    i_periph_flag[s] <= 1'b1;
    i_periph_en[s] <= 1'b1;
  endtask

  task automatic clr(input int s);
    tick(1);
    i_periph_flag[s] <= 1'b0;
    i_src_clear[s] <= 1'b1;
    tick(1);
    i_src_clear[s] <= 1'b0;
  endtask

  task automatic idle(output logic b);
    b = 1'b0;
    repeat (20) begin
      look(1);
      b = b | o_busy;
    end
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_prio();
    wprio(1, 8'hCF, 8'hCF);
    wprio(1, 8'h64, 8'h44);
    wprio(2, 8'hAA, 8'hFF);
    wprio(3, 8'h00, 8'hF0);
    wprio(0, 8'h3F, 8'h3F);
    wprio(1, 8'hF1, 8'hF1);
    $display("priority test done");
  endtask

  task automatic t_arb();
    logic b;
    setcc(8'hF2);
    tick(1);
    i_periph_flag[3] <= 1'b1;
    idle(b);
    `CHK("masked", 1'b0, b)
    tick(1);
    i_periph_en[5:3] <= 3'b111;
    i_periph_flag[5:3] <= 3'b111;
    enter(16'hFFF4, 2'b00, 8'hF2, 5);
    clr(3);
    idle(b);
    `CHK("same level", 1'b0, b)
    ret(8'hF2);
    enter(16'hFFF0, 2'b00, 8'hF2, 5);
    clr(5);
    i_concurrent_mode <= 1'b1;
    ret(8'hF2);
    enter(16'hFFF2, 2'b01, 8'hF2, 5);
    raise(5);
    idle(b);
    `CHK("concurrent", 1'b0, b)
    clr(4);
    ret(8'hF2);
    enter(16'hFFF0, 2'b00, 8'hF2, 5);
    clr(5);
    i_concurrent_mode <= 1'b0;
    ret(8'hF2);
    $display("arbitration test done");
  endtask

  task automatic t_nmi();
    tick(1);
    slow <= 1'b1;
    setcc(8'hFA);
    tick(1);
    i_trap <= 1'b1;
    tick(1);
    i_trap <= 1'b0;
    enter(16'hFFFC, 2'b11, 8'hFA, 5);
    tick(1);
    i_top_level_pin_irq <= 1'b0;
    enter(16'hFFFA, 2'b11, 8'hFA, 5);
    ret(8'hFA);
    ret(8'hFA);
    tick(1);
    i_top_level_pin_irq <= 1'b1;
    slow <= 1'b0;
    $display("non maskable test done");
  endtask

  task automatic t_ext();
    logic b;
    setcc(8'hF2);
    tick(1);
    i_ext_pin_sel[1:0] <= 2'b11;
    i_ext_pins[1:0] <= 2'b11;
    idle(b);
    `CHK("nand low", 1'b0, b)
    tick(1);
    i_ext_pins[1] <= 1'b0;
    enter(16'hFFF6, 2'b11, 8'hF2, 5);
    tick(1);
    i_ext_pins[1] <= 1'b1;
    ret(8'hF2);
    tick(1);
    i_ext_pins[8] <= 1'b1;
    i_ext_pin_sel[8] <= 1'b1;
    i_ext_sense_select[3:2] <= 2'b01;
    tick(1);
    i_ext_pins[8] <= 1'b0;
    enter(16'hFFEE, 2'b11, 8'hF2, 5);
    ret(8'hF2);
    idle(b);
    `CHK("edge cleared", 1'b0, b)
    $display("external test done");
  endtask

  task automatic t_halt();
    tick(1);
    i_halt_mode <= 1'b1;
    raise(3);
    look(5);
    `CHK("halt no wake", 1'b0, o_wake)
    `CHK("irq", 5'h15, o_irq)
    raise(5);
    look(4);
    `CHK("halt wake", 1'b1, o_wake)
    tick(1);
    i_halt_mode <= 1'b0;
    enter(16'hFFF0, 2'b00, 8'hF2, 5);
    clr(5);
    ret(8'hF2);
    enter(16'hFFF4, 2'b00, 8'hF2, 5);
    clr(3);
    ret(8'hF2);
    tick(1);
    i_wait_mode <= 1'b1;
    raise(4);
    look(4);
    `CHK("wait wake", 1'b1, o_wake)
    tick(1);
    i_wait_mode <= 1'b0;
    enter(16'hFFF2, 2'b01, 8'hF2, 5);
    clr(4);
    ret(8'hF2);
    $display("low power test done");
  endtask

  initial begin
    {i_sys_rst, i_top_level_pin_irq} = 2'b11;
    {i_trap, i_prio_wr_en, i_cc_wr_en, i_return_from_irq, i_wait_mode, i_halt_mode} = '0;
    {i_concurrent_mode, slow, i_prio_wr_idx, i_prio_wr_data, i_cc_wr_data, i_pop_cc} = '0;
    {i_periph_flag, i_periph_en, i_src_clear, i_ext_pins, i_ext_pin_sel, i_ext_sense_select} = '0;
    look(2);
    `CHK("prio reset", 32'hFFFFFFFF, o_vector_priority_regs)
    `CHK("flags reset", 8'hFA, o_cpu_flags_register)
    tick(1);
    i_sys_rst <= 1'b0;
    enter(16'hFFFE, 2'b11, 8'h00, 0);
    $display("reset test done");
    t_prio();
    t_arb();
    t_nmi();
    t_ext();
    t_halt();
    report_and_stop();
  end
endmodule
